// >>> verilog/tfc_pkg.sv
// Package for the transfer-format control block: map, fields, types
package tfc_pkg;
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [1:0] OFF_FORMAT = 2'h0;
   localparam logic [1:0] OFF_CONTROL = 2'h1;
   localparam logic [1:0] OFF_DATA = 2'h2;
   localparam logic [1:0] OFF_STATUS = 2'h3;
   // Format register fields
   localparam int FMT_ORDER_BIT = 7;
   localparam int FMT_WAIT_BIT = 6;
   localparam int FMT_RSV_HI_BIT = 5;
   localparam int FMT_RSV_LO_BIT = 4;
   localparam int FMT_GUARD_BIT = 3;
   localparam int FMT_BC_MSB = 2;
   localparam int FMT_BC_LSB = 0;
   localparam logic [1:0] FMT_RSV_VALUE = 2'h3;
   localparam logic FMT_GUARD_READ = 1'b1;
   // Control register fields
   localparam int CTL_SYNC_BIT = 0;
   localparam int CTL_MASTER_BIT = 1;
   localparam int CTL_START_BIT = 2;
   // Status register fields
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_ACK_BIT = 1;
   localparam int STS_LEN_LSB = 4;
   localparam int STS_LEN_MSB = 7;
   // Reset values
   localparam logic RST_ORDER = 1'b0;
   localparam logic RST_WAIT = 1'b0;
   localparam logic [2:0] RST_BC = 3'h0;
   localparam logic [7:0] RST_DATA = 8'h00;
   // Bit-count decoding
   localparam logic [3:0] BC_ZERO_TWO_WIRE = 4'h9;
   localparam logic [3:0] BC_ZERO_SYNC = 4'h8;
   localparam logic [3:0] BC_OFS_TWO_WIRE = 4'h1;
   // Wait length in half transfer-clock periods (two full periods)
   localparam logic [2:0] WAIT_HALVES = 3'h4;
   localparam int CLK_PERIOD_NS = 50;

   typedef struct packed {
      logic order;
      logic wait_en;
      logic [2:0] bc;
   } tfc_fmt_t;

   typedef struct packed {
      logic sync_fmt;
      logic master;
   } tfc_mode_t;

   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_WAIT} tfc_state_t;
endpackage

// >>> verilog/tfc_half_timer.sv
// Half-period tick generator for the transfer clock
`timescale 1ns/1ps
module tfc_half_timer
   import tfc_pkg::*;
#(
   parameter int HALF_CYC = 4
) (
   input wire logic clk_in, // System clock
   input wire logic nrst_in, // Synchronous reset, active low
   input wire logic run_in, // Count while high, clear while low
   output logic tick_out // One-cycle pulse per half period
);
   localparam int CW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);
   logic [CW-1:0] cnt_reg;

   if (HALF_CYC < 1) begin : g_chk
      $error("HALF_CYC must be at least one");
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in || !run_in) begin
         cnt_reg <= '0;
      end else if (cnt_reg == LAST) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= run_in && (cnt_reg == LAST);
      end
   end
endmodule

// >>> verilog/tfc_top.sv
// Transfer-format control register with a small serial shift engine
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module tfc_top
   import tfc_pkg::*;
#(
   parameter int HALF_CYC = 4
) (
   input wire logic CLK_IN, // System clock, 20 MHz
   input wire logic NRST_IN, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] ADDR_IN, // Register address
   input wire logic [DATA_W-1:0] WDATA_IN, // Write data
   input wire logic WR_IN, // Write strobe
   input wire logic RD_IN, // Read strobe
   output logic [DATA_W-1:0] RDATA_OUT, // Read data, cycle after strobe
   output logic SCL_OUT, // Serial clock
   output logic SDA_OUT, // Serial data drive level
   output logic SDA_OEN_OUT, // Low while driving SDA
   input wire logic SDA_IN, // Serial data pin level
   output logic BUSY_OUT // Transfer in progress
);
   if (DATA_W != 8 || ADDR_W != 2) begin : g_chk
      $error("Bus widths are fixed at 8 data and 2 address bits");
   end

   // Total bits in one transfer for a given code and format
   function automatic logic [3:0] total_bits(input logic [2:0] bc,
                                             input logic sync_fmt);
      logic [3:0] n;
      n = {1'b0, bc};
      if (bc == RST_BC) begin
         total_bits = sync_fmt ? BC_ZERO_SYNC : BC_ZERO_TWO_WIRE;
      end else begin
         total_bits = sync_fmt ? n : 4'(n + BC_OFS_TWO_WIRE);
      end
   endfunction

   tfc_fmt_t fmt_reg;
   tfc_mode_t mode_reg;
   tfc_state_t state_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [3:0] bits_left_reg;
   logic [2:0] wait_cnt_reg;
   logic ack_reg;
   logic start;
   logic tick;
   logic wait_eff;
   logic out_bit;
   logic [7:0] tx_shifted;
   logic [7:0] format_view;

   assign start = WR_IN && (ADDR_IN == OFF_CONTROL) &&
                  WDATA_IN[CTL_START_BIT] && (state_reg == ST_IDLE);
   // Only a two-wire master honours the wait bit
   assign wait_eff = fmt_reg.wait_en && mode_reg.master &&
                     !mode_reg.sync_fmt;
   assign out_bit = fmt_reg.order ? tx_reg[0] : tx_reg[7];
   assign tx_shifted = fmt_reg.order ? {1'b0, tx_reg[7:1]} :
                       {tx_reg[6:0], 1'b0};
   assign format_view = {fmt_reg.order, fmt_reg.wait_en, FMT_RSV_VALUE,
                         FMT_GUARD_READ, fmt_reg.bc};

   tfc_half_timer #(
      .HALF_CYC(HALF_CYC)
   ) tfc_half_timer_i (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .run_in(state_reg != ST_IDLE),
      .tick_out(tick)
   );

   // Format register; reserved bits have no storage
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         fmt_reg.order <= RST_ORDER;
         fmt_reg.wait_en <= RST_WAIT;
         fmt_reg.bc <= RST_BC;
      end else if (WR_IN && ADDR_IN == OFF_FORMAT) begin
         fmt_reg.order <= WDATA_IN[FMT_ORDER_BIT];
         fmt_reg.wait_en <= WDATA_IN[FMT_WAIT_BIT];
         if (!WDATA_IN[FMT_GUARD_BIT]) begin
            fmt_reg.bc <= WDATA_IN[FMT_BC_MSB:FMT_BC_LSB];
         end
      end
   end

   // Mode register; changing it mid-transfer is the writer's problem
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         mode_reg <= '0;
      end else if (WR_IN && ADDR_IN == OFF_CONTROL) begin
         mode_reg.sync_fmt <= WDATA_IN[CTL_SYNC_BIT];
         mode_reg.master <= WDATA_IN[CTL_MASTER_BIT];
      end
   end

   // Read port, data valid only in the cycle after the strobe
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         RDATA_OUT <= '0;
      end else if (RD_IN) begin
         if (ADDR_IN == OFF_FORMAT) begin
            RDATA_OUT <= format_view;
         end else if (ADDR_IN == OFF_CONTROL) begin
            RDATA_OUT <= {6'h00, mode_reg.master, mode_reg.sync_fmt};
         end else if (ADDR_IN == OFF_DATA) begin
            RDATA_OUT <= rx_reg;
         end else begin
            RDATA_OUT <= {total_bits(fmt_reg.bc, mode_reg.sync_fmt),
                          2'h0, ack_reg, state_reg != ST_IDLE};
         end
      end else begin
         RDATA_OUT <= '0;
      end
   end

   // Transfer sequencer
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         state_reg <= ST_IDLE;
         bits_left_reg <= '0;
         wait_cnt_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg <= ST_LOW;
                  // Start write may switch format in the same cycle
                  bits_left_reg <= total_bits(fmt_reg.bc,
                     WDATA_IN[CTL_SYNC_BIT]);
               end
            end
            ST_LOW: begin
               if (tick) begin
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tick) begin
                  bits_left_reg <= bits_left_reg - 1'b1;
                  if (bits_left_reg == 4'h1) begin
                     state_reg <= ST_IDLE;
                  end else if (bits_left_reg == 4'h2 && wait_eff) begin
                     // Next bit is the acknowledge: stretch before it
                     state_reg <= ST_WAIT;
                     wait_cnt_reg <= WAIT_HALVES - 1'b1;
                  end else begin
                     state_reg <= ST_LOW;
                  end
               end
            end
            ST_WAIT: begin
               if (tick) begin
                  if (wait_cnt_reg == '0) begin
                     state_reg <= ST_LOW;
                  end else begin
                     wait_cnt_reg <= wait_cnt_reg - 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Serial clock: low in the low and wait phases, high in the high phase and in idle
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         SCL_OUT <= 1'b1;
      end else if (state_reg == ST_LOW && tick) begin
         SCL_OUT <= 1'b1;
      end else if (start || (state_reg == ST_HIGH && tick &&
                             bits_left_reg != 4'h1)) begin
         SCL_OUT <= 1'b0;
      end else if (state_reg == ST_HIGH && tick) begin
         SCL_OUT <= 1'b1;
      end
   end

   // Data shifter and open-drain data drive
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         tx_reg <= RST_DATA;
         SDA_OEN_OUT <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
         if (WR_IN && ADDR_IN == OFF_DATA) begin
            tx_reg <= WDATA_IN;
         end
         if (start) begin
            SDA_OEN_OUT <= out_bit;
         end else begin
            SDA_OEN_OUT <= 1'b1;
         end
      end else if (state_reg == ST_HIGH && tick) begin
         tx_reg <= tx_shifted;
         if (bits_left_reg == 4'h1) begin
            SDA_OEN_OUT <= 1'b1;
         end else if (bits_left_reg == 4'h2 && !mode_reg.sync_fmt) begin
            SDA_OEN_OUT <= 1'b1; // Release for acknowledge
         end else begin
            SDA_OEN_OUT <= fmt_reg.order ? tx_reg[1] : tx_reg[6];
         end
      end
   end

   // Pin level is always low when enabled
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         SDA_OUT <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
      end
   end

   // Receive capture at the tick that ends each high phase
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         rx_reg <= RST_DATA;
         ack_reg <= 1'b0;
      end else if (state_reg == ST_HIGH && tick) begin
         if (bits_left_reg == 4'h1 && !mode_reg.sync_fmt) begin
            ack_reg <= !SDA_IN;
         end else if (fmt_reg.order) begin
            rx_reg <= {SDA_IN, rx_reg[7:1]};
         end else begin
            rx_reg <= {rx_reg[6:0], SDA_IN};
         end
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         BUSY_OUT <= 1'b0;
      end else begin
         BUSY_OUT <= start || (state_reg != ST_IDLE &&
                     !(state_reg == ST_HIGH && tick &&
                       bits_left_reg == 4'h1));
      end
   end

   // Checks
   int unsigned wait_len;
   localparam int unsigned WAIT_CYC = 4 * HALF_CYC;

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN || state_reg != ST_WAIT) begin
         wait_len <= 0;
      end else begin
         wait_len <= wait_len + 1;
      end
   end

   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);

   sequence seq_fmt_write;
      WR_IN && ADDR_IN == OFF_FORMAT;
   endsequence
   sequence seq_fmt_read;
      RD_IN && ADDR_IN == OFF_FORMAT;
   endsequence
   sequence seq_wait_enter;
      state_reg == ST_HIGH && tick ##1 state_reg == ST_WAIT;
   endsequence

   chk_order_write: assert property (seq_fmt_write |=>
      fmt_reg.order == $past(WDATA_IN[FMT_ORDER_BIT]))
      else $error("order bit did not take written value");
   chk_reserved_ones: assert property (seq_fmt_read |=>
      RDATA_OUT[FMT_RSV_HI_BIT:FMT_RSV_LO_BIT] == FMT_RSV_VALUE)
      else $error("reserved bits did not read one");
   chk_guard_read: assert property (seq_fmt_read |=>
      RDATA_OUT[FMT_GUARD_BIT] && RDATA_OUT[FMT_BC_MSB:0] == fmt_reg.bc)
      else $error("guard or count read back wrong");
   chk_count_load: assert property (
      seq_fmt_write and !WDATA_IN[FMT_GUARD_BIT] |=>
      fmt_reg.bc == $past(WDATA_IN[FMT_BC_MSB:FMT_BC_LSB]))
      else $error("count not loaded with guard clear");
   chk_count_hold: assert property (
      seq_fmt_write and WDATA_IN[FMT_GUARD_BIT] |=> $stable(fmt_reg.bc))
      else $error("count changed with guard set");
   chk_wait_scl_low: assert property (seq_wait_enter |->
      !SCL_OUT throughout (state_reg == ST_WAIT)[*2])
      else $error("clock not held low in wait");
   chk_wait_length: assert property (
      state_reg == ST_WAIT ##1 state_reg != ST_WAIT |->
      $past(wait_len) == WAIT_CYC - 1)
      else $error("wait length wrong");
   chk_wait_before_ack: assert property (state_reg == ST_WAIT |->
      bits_left_reg == 4'h1 && !mode_reg.sync_fmt)
      else $error("wait not just before acknowledge");
   chk_wait_gated: assert property (state_reg == ST_WAIT |->
      fmt_reg.wait_en && mode_reg.master && !mode_reg.sync_fmt)
      else $error("wait inserted while not enabled");
   chk_len_two_wire: assert property (
      start && !WDATA_IN[CTL_SYNC_BIT] |=> bits_left_reg ==
      (($past(fmt_reg.bc) == 3'h0) ? 4'h9 : {1'b0, $past(fmt_reg.bc)} + 4'h1))
      else $error("two-wire length wrong");
   chk_len_sync: assert property (
      start && WDATA_IN[CTL_SYNC_BIT] |=> bits_left_reg ==
      (($past(fmt_reg.bc) == 3'h0) ? 4'h8 : {1'b0, $past(fmt_reg.bc)}))
      else $error("synchronous length wrong");
endmodule

// >>> test/tfc_bus_dev.sv
// Serial bus device model: samples data, answers acknowledge
`timescale 1ns/1ps
module tfc_bus_dev (
   input wire logic clk_in, // System clock
   input wire logic clr_in, // Clear between transfers
   input wire logic scl_in, // Bus clock
   input wire logic sda_in, // Bus data wire level
   input wire logic [3:0] nbits_in, // Bits in this transfer
   input wire logic ack_en_in, // Pull the acknowledge bit low
   output logic pull_out, // High while pulling SDA low
   output logic [7:0] rx_out // Bits seen, newest at bit 0
);
   logic scl_d;
   logic [3:0] rises;
   // Pull only after SCL falls, hold through the high phase
   assign pull_out = ack_en_in &&
      ((rises == nbits_in - 4'h1 && (!scl_in || !scl_d)) ||
      (rises == nbits_in && scl_in));
   always @(posedge clk_in) begin
      scl_d <= scl_in;
      if (clr_in) begin
         rises <= 4'h0;
         rx_out <= 8'h00;
      end else if (scl_in && !scl_d) begin
         rises <= rises + 4'h1;
         rx_out <= {rx_out[6:0], sda_in};
      end
   end
endmodule

// >>> test/i2c_transfer_format_control_tb.sv
// Testbench for the transfer-format register and shift engine
`timescale 1ns/1ps
module i2c_transfer_format_control_tb;
   import tfc_pkg::*;
   localparam int H = 2;
   typedef struct packed {
      logic [7:0] exp;
      logic [7:0] mask;
   } tfc_rd_t;
   typedef struct packed {
      logic [7:0] rx;
      logic [3:0] rises;
      logic [7:0] ext;
   } tfc_xf_t;
   logic CLK_IN = 1'b0;
   logic NRST_IN = 1'b0;
   logic [ADDR_W-1:0] ADDR_IN = '0;
   logic [DATA_W-1:0] WDATA_IN = '0;
   logic WR_IN = 1'b0;
   logic RD_IN = 1'b0;
   logic [DATA_W-1:0] RDATA_OUT;
   logic SCL_OUT, SDA_OUT, SDA_OEN_OUT, BUSY_OUT, sda_w, pull;
   logic dev_clr = 1'b0, ack_en = 1'b0;
   logic [3:0] nbits = 4'h0;
   logic [7:0] dev_rx;
   logic rd_d = 1'b0, busy_d = 1'b0, scl_d = 1'b1;
   logic [3:0] rise_n = 4'h0;
   logic [7:0] low_n = 8'h00;
   logic [7:0] lows [16];
   logic [7:0] fmt = 8'h38;
   tfc_rd_t rd_q [$];
   tfc_xf_t xf_q [$];
   int mismatches = 0, samples_checked = 0, cycles = 0;

   // Open-drain wire with pull-up
   assign sda_w = (SDA_OEN_OUT | SDA_OUT) & ~pull;

   tfc_top #(.HALF_CYC(H)) tfc_top_i (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
      .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
      .RDATA_OUT(RDATA_OUT), .SCL_OUT(SCL_OUT), .SDA_OUT(SDA_OUT),
      .SDA_OEN_OUT(SDA_OEN_OUT), .SDA_IN(sda_w), .BUSY_OUT(BUSY_OUT));
   tfc_bus_dev tfc_bus_dev_i (.clk_in(CLK_IN), .clr_in(dev_clr),
      .scl_in(SCL_OUT), .sda_in(sda_w), .nbits_in(nbits),
      .ack_en_in(ack_en), .pull_out(pull), .rx_out(dev_rx));

   initial forever #25 CLK_IN = ~CLK_IN;

   function automatic logic [3:0] len(input logic s, input logic [2:0] c);
      if (s)
         return c == 3'h0 ? 4'h8 : {1'b0, c};
      return c == 3'h0 ? 4'h9 : {1'b0, c} + 4'h1;
   endfunction

   task automatic summarize();
      if (rd_q.size() + xf_q.size() > 0)
         mismatches++;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_reg(input string n, input logic [7:0] e, s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cmp_link(input string n, input logic [7:0] e, s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      WDATA_IN <= d;
      WR_IN <= 1'b1;
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      rd_q.push_back('{e, m});
      @(posedge CLK_IN);
      RD_IN <= 1'b0;
   endtask

   // Format write, then read back against the local copy
   task automatic wf(input logic [7:0] d);
      wr(OFF_FORMAT, d);
      fmt = {d[7:6], 2'b11, 1'b1, d[3] ? fmt[2:0] : d[2:0]};
      rd(OFF_FORMAT, fmt, 8'hff);
   endtask

   task automatic xfer(input logic s, m, w, o, input logic [2:0] c,
      input logic a);
      logic [7:0] d, e, x;
      logic [3:0] n;
      int k;
      d = 8'($urandom());
      n = len(s, c);
      e = 8'h00;
      for (k = 0; k < n - (s ? 0 : 1); k++)
         e = {e[6:0], o ? d[k] : d[7-k]};
      if (!s)
         e = {e[6:0], ~a};
      x = (m && !s && w) ? 8'(4 * H) : 8'h00;
      // Order goes back to 0 while still synchronous, count kept
      if (fmt[7])
         wf({1'b0, fmt[6], 6'h08});
      wr(OFF_CONTROL, 8'h00);
      wf({1'b0, w, 3'b000, c});
      wr(OFF_CONTROL, {6'h00, m, s});
      // Order 1 only once the synchronous format is set
      if (o)
         wf({o, w, 3'b001, c});
      wr(OFF_DATA, d);
      nbits <= n;
      ack_en <= a;
      dev_clr <= 1'b1;
      xf_q.push_back('{e, n, x});
      wr(OFF_CONTROL, {5'h00, 1'b1, m, s});
      dev_clr <= 1'b0;
      for (k = 0; k < 400 && BUSY_OUT !== 1'b1; k++)
         @(negedge CLK_IN);
      for (k = 0; k < 400 && BUSY_OUT !== 1'b0; k++)
         @(negedge CLK_IN);
      if (!s)
         rd(OFF_STATUS, {6'h00, a, 1'b0}, 8'h02);
   endtask

   // Result watcher: register reads and finished transfers
   always @(posedge CLK_IN) begin
      tfc_rd_t r;
      tfc_xf_t x;
      cycles++;
      rd_d <= RD_IN;
      busy_d <= BUSY_OUT;
      scl_d <= SCL_OUT;
      if (rd_d && rd_q.size() > 0) begin
         r = rd_q.pop_front();
         cmp_reg("read data", r.exp, RDATA_OUT & r.mask);
      end
      if (BUSY_OUT && !busy_d) begin
         rise_n <= 4'h0;
         low_n <= 8'h00;
      end else if (SCL_OUT && !scl_d) begin
         lows[rise_n] <= low_n;
         rise_n <= rise_n + 4'h1;
         low_n <= 8'h00;
      end else if (!SCL_OUT)
         low_n <= low_n + 8'h01;
      if (!BUSY_OUT && busy_d && xf_q.size() > 0) begin
         x = xf_q.pop_front();
         cmp_link("bits seen", x.rx, dev_rx);
         cmp_link("clock pulses", {4'h0, x.rises}, {4'h0, rise_n});
         cmp_link("low stretch", x.ext,
            lows[x.rises-4'h1] - lows[x.rises-4'h2]);
      end
   end

   // Ceiling well above the longest expected run; a hang reports here
   always @(posedge CLK_IN) begin
      if (cycles >= 20000) begin
         mismatches++;
         summarize();
      end
   end

   initial begin
      int i;
      i = $urandom(32'h4931934e);
      repeat (16) @(posedge CLK_IN);
      NRST_IN <= 1'b1;
      rd(OFF_FORMAT, 8'h38, 8'hff);
      wf(8'h05);
      wf(8'h0a);
      wf(8'h7f);
      wf(8'h30);
      for (i = 0; i < 8; i++)
         wf(8'($urandom()) & 8'h7f);
      for (i = 0; i < 16; i++) begin
         wr(OFF_CONTROL, 8'h00);
         wf({5'h00, i[2:0]});
         wr(OFF_CONTROL, {7'h00, i[3]});
         rd(OFF_STATUS, {len(i[3], i[2:0]), 4'h0}, 8'hf0);
      end
      xfer(0, 1, 1, 0, 3'h2, 1);
      xfer(0, 1, 0, 0, 3'h2, 0);
      xfer(0, 0, 1, 0, 3'h0, 1);
      xfer(0, 1, 1, 0, 3'h7, 1);
      xfer(1, 1, 1, 0, 3'h0, 0);
      xfer(1, 1, 0, 1, 3'h0, 0);
      xfer(1, 1, 1, 1, 3'h7, 0);
      xfer(1, 0, 0, 0, 3'($urandom_range(7, 2)), 0);
      @(posedge CLK_IN);
      NRST_IN <= 1'b0;
      repeat (2) @(posedge CLK_IN);
      NRST_IN <= 1'b1;
      fmt = 8'h38;
      rd(OFF_FORMAT, 8'h38, 8'hff);
      repeat (3) @(posedge CLK_IN);
      summarize();
   end
endmodule
